//--- spr_pkg.sv
// Purpose: shared constants and carriers for the port PIO setup recovery block
// Assumes: 32-bit APB, byte addresses, one aligned word per register
// Notes:   offsets below are the block's own register map
package spr_pkg;
  // ------------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------------
  localparam logic [11:0] OFF_INT_STATUS = 12'h010;
  localparam logic [11:0] OFF_TASK_FILE  = 12'h020;
  localparam logic [11:0] OFF_SERIAL_CTL = 12'h02c;
  localparam logic [11:0] OFF_CMD_ISSUE  = 12'h038;
  localparam logic [11:0] OFF_PORT_STATE = 12'h040;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PIO_SETUP_BIT = 1;
  localparam int BUSY_BIT      = 7;
  localparam int DRQ_BIT       = 3;
  localparam int DET_LSB       = 0;
  localparam int DET_W         = 4;
  localparam int CI_ISSUE_BIT  = 0;
  localparam int CI_SRST_BIT   = 1;
  localparam int CI_FISC_BIT   = 2;
  localparam int CI_HDRC_BIT   = 3;
  localparam int CI_HDRR_BIT   = 4;
  localparam int PS_LOCK_BIT   = 0;
  localparam int PS_SRST_BIT   = 1;
  localparam int PS_COMR_BIT   = 2;
  // ------------------------------------------------------------------
  // reset values and codes
  // ------------------------------------------------------------------
  localparam logic [31:0] INT_STATUS_RST = 32'h0000_0000;
  localparam logic [7:0]  TASK_FILE_RST  = 8'h7f;
  localparam logic [3:0]  DET_RST        = 4'h0;
  localparam logic [3:0]  DET_COMRESET   = 4'h1;
  localparam logic [1:0]  FRM_REG_D2H    = 2'h0;
  localparam logic [1:0]  FRM_PIO_SETUP  = 2'h1;

  // ------------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       valid;
    logic [1:0] kind;
    logic       dir_to_host;
    logic [7:0] status;
  } spr_rx_frame_t;

  typedef struct packed {
    logic srst;
    logic fis_c;
    logic hdr_c;
    logic hdr_r;
  } spr_tx_frame_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_LOCK = 2'b01,
    ST_SRST = 2'b11,
    ST_COMR = 2'b10
  } spr_state_t;
endpackage : spr_pkg

//--- spr_port.sv
// Purpose: one serial ATA port, PIO setup handling and stall recovery
// Assumes: frame layer runs on pclk; APB slave with one wait state
// Notes:   lock is cleared by the two-frame software reset or by COMRESET
//
// Behaviour
// - PIO setup frame of either direction sets status bit one in the run state
// - task-file status shows drive busy at bit 7
// - task-file status shows data request at bit 3
// - write setup frame locks port if busy and data request were both clear before it
// - detection field one drives COMRESET on link
module spr_port (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // frames from the drive
  input  wire spr_pkg::spr_rx_frame_t rx_frame,
  // frames to the drive
  output spr_pkg::spr_tx_frame_t      tx_frame,
  output logic                        tx_valid,
  input  wire logic                   tx_ready,
  // link signalling
  output logic                        comreset
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  spr_pkg::spr_state_t    state_r,     state_nxt;
  logic [31:0]            int_r,       int_nxt;
  logic [7:0]             tfd_r,       tfd_nxt;
  logic [3:0]             det_r,       det_nxt;
  spr_pkg::spr_tx_frame_t txf_r,       txf_nxt;
  logic                   txv_r,       txv_nxt;
  logic                   comr_r,      comr_nxt;
  logic [31:0]            prdata_r,    prdata_nxt;
  logic                   pready_r,    pready_nxt;
  logic                   pslverr_r,   pslverr_nxt;

  logic                   acc;
  logic                   wr_done;
  logic                   mapped;
  logic                   tx_fire;
  logic                   pio_wr;
  logic                   lock_hit;

  assign acc      = psel && penable && !pready_r;
  assign wr_done  = psel && penable && pready_r && pwrite && !pslverr_r;
  assign tx_fire  = txv_r && tx_ready;
  assign pio_wr   = rx_frame.valid && rx_frame.kind == spr_pkg::FRM_PIO_SETUP && !rx_frame.dir_to_host;
  // flags as held when the frame lands, before it updates them
  assign lock_hit = pio_wr && !tfd_r[spr_pkg::BUSY_BIT] && !tfd_r[spr_pkg::DRQ_BIT];

  always_comb begin
    unique case (paddr)
      spr_pkg::OFF_INT_STATUS,
      spr_pkg::OFF_TASK_FILE,
      spr_pkg::OFF_SERIAL_CTL,
      spr_pkg::OFF_CMD_ISSUE,
      spr_pkg::OFF_PORT_STATE: mapped = 1'b1;
      default:                 mapped = 1'b0;
    endcase
  end

  // ------------------------------------------------------------------
  // apb answer: one wait state so read data comes from a flop
  // ------------------------------------------------------------------
  always_comb begin
    pready_nxt  = acc;
    pslverr_nxt = acc && !mapped;
    prdata_nxt  = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (paddr)
        spr_pkg::OFF_INT_STATUS: prdata_nxt = int_r;
        spr_pkg::OFF_TASK_FILE:  prdata_nxt = {24'h00_0000, tfd_r};
        spr_pkg::OFF_SERIAL_CTL: prdata_nxt = {28'h000_0000, det_r};
        spr_pkg::OFF_CMD_ISSUE:  prdata_nxt = {27'h000_0000, txf_r.hdr_r, txf_r.hdr_c,
                                               txf_r.fis_c, txf_r.srst, txv_r};
        spr_pkg::OFF_PORT_STATE: prdata_nxt = {29'h0000_0000, state_r == spr_pkg::ST_COMR,
                                               state_r == spr_pkg::ST_SRST,
                                               state_r == spr_pkg::ST_LOCK};
        default:                 prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r  <= prdata_nxt;
    end
  end

  // ------------------------------------------------------------------
  // port registers, frame handling and recovery
  // ------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    int_nxt   = int_r;
    tfd_nxt   = tfd_r;
    det_nxt   = det_r;
    txf_nxt   = txf_r;
    txv_nxt   = txv_r;
    comr_nxt  = comr_r;

    // software writes first so hardware sets below win over a clear
    if (wr_done) begin
      unique case (paddr)
        spr_pkg::OFF_INT_STATUS: int_nxt = int_r & ~pwdata;
        spr_pkg::OFF_SERIAL_CTL: det_nxt = pwdata[spr_pkg::DET_LSB +: spr_pkg::DET_W];
        spr_pkg::OFF_CMD_ISSUE: begin
          // one-deep list: an issue while a frame waits is dropped
          if (pwdata[spr_pkg::CI_ISSUE_BIT] && !txv_r) begin
            txv_nxt       = 1'b1;
            txf_nxt.srst  = pwdata[spr_pkg::CI_SRST_BIT];
            txf_nxt.fis_c = pwdata[spr_pkg::CI_FISC_BIT];
            txf_nxt.hdr_c = pwdata[spr_pkg::CI_HDRC_BIT];
            txf_nxt.hdr_r = pwdata[spr_pkg::CI_HDRR_BIT];
          end
        end
        default: ;
      endcase
    end

    if (tx_fire) begin
      txv_nxt = 1'b0;
      // clear-busy-on-acknowledge
      if (txf_r.hdr_c) tfd_nxt[spr_pkg::BUSY_BIT] = 1'b0;
    end

    unique case (state_r)
      spr_pkg::ST_RUN: begin
        if (rx_frame.valid) begin
          tfd_nxt = rx_frame.status;
          if (rx_frame.kind == spr_pkg::FRM_PIO_SETUP) begin
            int_nxt[spr_pkg::PIO_SETUP_BIT] = 1'b1;
          end
        end
        if (lock_hit) state_nxt = spr_pkg::ST_LOCK;
      end
      spr_pkg::ST_LOCK: begin
        if (tx_fire && txf_r.srst && txf_r.hdr_r && txf_r.hdr_c) state_nxt = spr_pkg::ST_SRST;
      end
      spr_pkg::ST_SRST: begin
        if (tx_fire && !txf_r.srst && !txf_r.hdr_r && !txf_r.hdr_c) state_nxt = spr_pkg::ST_RUN;
        else if (tx_fire) state_nxt = spr_pkg::ST_LOCK;
      end
      spr_pkg::ST_COMR: begin
        if (det_r != spr_pkg::DET_COMRESET) state_nxt = spr_pkg::ST_RUN;
      end
      default: state_nxt = spr_pkg::ST_RUN;
    endcase

    if (det_r == spr_pkg::DET_COMRESET) begin
      state_nxt = spr_pkg::ST_COMR;
      tfd_nxt   = spr_pkg::TASK_FILE_RST;
    end
    comr_nxt = (det_nxt == spr_pkg::DET_COMRESET);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= spr_pkg::ST_RUN;
      int_r   <= spr_pkg::INT_STATUS_RST;
      tfd_r   <= spr_pkg::TASK_FILE_RST;
      det_r   <= spr_pkg::DET_RST;
      txf_r   <= '0;
      txv_r   <= 1'b0;
      comr_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      int_r   <= int_nxt;
      tfd_r   <= tfd_nxt;
      det_r   <= det_nxt;
      txf_r   <= txf_nxt;
      txv_r   <= txv_nxt;
      comr_r  <= comr_nxt;
    end
  end

  assign prdata   = prdata_r;
  assign pready   = pready_r;
  assign pslverr  = pslverr_r;
  assign tx_frame = txf_r;
  assign tx_valid = txv_r;
  assign comreset = comr_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_reset;
    tx_fire && txf_r.srst && txf_r.hdr_r && txf_r.hdr_c;
  endsequence
  sequence s_second_reset;
    tx_fire && !txf_r.srst && !txf_r.hdr_r && !txf_r.hdr_c;
  endsequence

  pio_flag_set_a: assert property (
    state_r == spr_pkg::ST_RUN && det_r != spr_pkg::DET_COMRESET && rx_frame.valid
      && rx_frame.kind == spr_pkg::FRM_PIO_SETUP |=> int_r[spr_pkg::PIO_SETUP_BIT])
    else $error("setup frame did not set status flag");

  busy_tracks_a: assert property (
    state_r == spr_pkg::ST_RUN && det_r != spr_pkg::DET_COMRESET && rx_frame.valid
      |=> tfd_r[spr_pkg::BUSY_BIT] == $past(rx_frame.status[spr_pkg::BUSY_BIT]))
    else $error("busy flag not taken from frame");

  drq_tracks_a: assert property (
    state_r == spr_pkg::ST_RUN && det_r != spr_pkg::DET_COMRESET && rx_frame.valid
      |=> tfd_r[spr_pkg::DRQ_BIT] == $past(rx_frame.status[spr_pkg::DRQ_BIT]))
    else $error("data request flag not taken from frame");

  lock_enter_a: assert property (
    state_r == spr_pkg::ST_RUN && lock_hit && det_r != spr_pkg::DET_COMRESET
      |=> state_r == spr_pkg::ST_LOCK)
    else $error("port did not stall on clear setup frame");

  lock_frozen_a: assert property (
    state_r == spr_pkg::ST_LOCK && rx_frame.valid && !tx_fire && det_r != spr_pkg::DET_COMRESET
      |=> $stable(tfd_r) && state_r == spr_pkg::ST_LOCK)
    else $error("stalled port advanced on a frame");

  first_reset_a: assert property (
    state_r == spr_pkg::ST_LOCK && det_r != spr_pkg::DET_COMRESET ##0 s_first_reset
      |=> state_r == spr_pkg::ST_SRST)
    else $error("first reset frame did not advance recovery");

  srst_unlock_a: assert property (
    state_r == spr_pkg::ST_SRST && det_r != spr_pkg::DET_COMRESET ##0 s_second_reset
      |=> state_r == spr_pkg::ST_RUN)
    else $error("two reset frames did not free the port");

  comreset_out_a: assert property (
    wr_done && paddr == spr_pkg::OFF_SERIAL_CTL
      |=> comreset == ($past(pwdata[spr_pkg::DET_LSB +: spr_pkg::DET_W]) == spr_pkg::DET_COMRESET)
      ##1 comreset == (det_r == spr_pkg::DET_COMRESET))
    else $error("comreset does not follow detection field");

  comreset_state_a: assert property (
    det_r == spr_pkg::DET_COMRESET |=> state_r == spr_pkg::ST_COMR && tfd_r == spr_pkg::TASK_FILE_RST)
    else $error("port reset did not reset port state");

  apb_wait_a: assert property (
    psel && penable && !pready |=> pready ##1 !pready || (psel && penable))
    else $error("apb answer not after one wait state");

  apb_unmapped_a: assert property (
    acc && !mapped |=> pready && pslverr)
    else $error("unmapped address not flagged");
endmodule // spr_port

//--- spr_drive_model.sv
// Purpose: behavioural serial ATA drive on the far side of the port
// Assumes: frame layer on pclk, one frame per send pulse
// Notes:   stall sets how long tx_ready stays low per frame
module spr_drive_model (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // bench control
  input  wire logic                   snd,
  input  wire spr_pkg::spr_rx_frame_t snd_f,
  input  wire logic [1:0]             stall,
  // port side
  output spr_pkg::spr_rx_frame_t      rx_frame,
  input  wire spr_pkg::spr_tx_frame_t tx_frame,
  input  wire logic                   tx_valid,
  output logic                        tx_ready,
  output spr_pkg::spr_tx_frame_t      got,
  output logic [7:0]                  got_n
);
  logic [1:0] wait_c;
  // idle status toggles so a stale value never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_frame <= '0;
    end else if (snd) begin
      rx_frame <= snd_f;
    end else begin
      rx_frame.valid  <= 1'b0;
      rx_frame.status <= ~rx_frame.status;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      wait_c   <= 2'h0;
      got_n    <= 8'h00;
      got      <= '0;
    end else begin
      tx_ready <= 1'b0;
      if (tx_valid && tx_ready) begin
        got_n  <= got_n + 8'h01;
        got    <= tx_frame;
        wait_c <= 2'h0;
      end else if (tx_valid) begin
        if (wait_c == stall) tx_ready <= 1'b1;
        else wait_c <= wait_c + 2'h1;
      end
    end
  end
endmodule // spr_drive_model

//--- test_sata_port_pio_setup_recovery.sv
// Purpose: self-checking bench for the port setup and recovery block
// Assumes: one wait state apb slave, drive model on the frame side
// Notes:   random frame status from a fixed xorshift seed
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_sata_port_pio_setup_recovery;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, snd = 0;
  logic                   pready, pslverr, tx_valid, tx_ready, comreset, er;
  logic [11:0]            paddr = '0;
  logic [31:0]            pwdata = '0, prdata, rd, r, seed = 32'h3c10a848;
  logic [7:0]             got_n, s, prev;
  logic [1:0]             stall = 2'h0;
  spr_pkg::spr_rx_frame_t rx_frame, snd_f = '0;
  spr_pkg::spr_tx_frame_t tx_frame, got;
  int                     bad_count = 0, check_count = 0;
  always #4 pclk = ~pclk;
  spr_port i_spr_port (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame(rx_frame),
    .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .comreset(comreset));
  spr_drive_model i_spr_drive_model (.pclk(pclk), .presetn(presetn), .snd(snd), .snd_f(snd_f), .stall(stall),
    .rx_frame(rx_frame), .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .got(got), .got_n(got_n));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic lk(logic [7:0] p, logic [1:0] k);
    return k == spr_pkg::FRM_PIO_SETUP && !p[spr_pkg::BUSY_BIT] && !p[spr_pkg::DRQ_BIT];
  endfunction
  task automatic results();
    if (bad_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // bus and frame tasks
  // ------------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin bad_count++; results(); end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic send(input logic [1:0] k, input logic [7:0] st);
    snd <= 1'b1;
    snd_f <= {1'b1, k, 1'b0, st};
    @(posedge pclk);
    snd <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic issue(input logic [31:0] d);
    logic [7:0] n0 = got_n;
    int n = 0;
    apb(1'b1, spr_pkg::OFF_CMD_ISSUE, d);
    while (got_n === n0 && n < 30) begin @(posedge pclk); n++; end
    if (got_n === n0) begin bad_count++; results(); end
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(spr_pkg::OFF_TASK_FILE, 32'h7f);
    rchk(spr_pkg::OFF_INT_STATUS, 32'h0);
    rchk(spr_pkg::OFF_SERIAL_CTL, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(er, 1'b1)
    prev = spr_pkg::TASK_FILE_RST;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      s = r[7:0] | (r[8] ? 8'h80 : 8'h08);
      send({1'b0, r[9]}, s);
      rchk(spr_pkg::OFF_TASK_FILE, {24'h0, s});
      rchk(spr_pkg::OFF_INT_STATUS, {30'h0, r[9], 1'b0});
      rchk(spr_pkg::OFF_PORT_STATE, {31'h0, lk(prev, {1'b0, r[9]})});
      apb(1'b1, spr_pkg::OFF_INT_STATUS, 32'h2);
      prev = s;
    end
    send(spr_pkg::FRM_REG_D2H, 8'h50);
    rchk(spr_pkg::OFF_PORT_STATE, 32'h0);
    send(spr_pkg::FRM_PIO_SETUP, 8'h41);
    rchk(spr_pkg::OFF_PORT_STATE, {31'h0, lk(8'h50, spr_pkg::FRM_PIO_SETUP)});
    send(spr_pkg::FRM_PIO_SETUP, 8'hff);
    rchk(spr_pkg::OFF_TASK_FILE, 32'h41);
    // slow drive during the two reset frames
    r = rnd();
    stall <= r[1:0];
    issue(32'h1b);
    `CHK(got, 4'hb)
    apb(1'b0, spr_pkg::OFF_PORT_STATE, 32'h0);
    `CHK(rd[spr_pkg::PS_SRST_BIT], 1'b1)
    issue(32'h01);
    `CHK(got, 4'h0)
    rchk(spr_pkg::OFF_PORT_STATE, 32'h0);
    send(spr_pkg::FRM_REG_D2H, 8'h80);
    send(spr_pkg::FRM_PIO_SETUP, 8'h88);
    rchk(spr_pkg::OFF_TASK_FILE, 32'h88);
    rchk(spr_pkg::OFF_PORT_STATE, 32'h0);
    send(spr_pkg::FRM_REG_D2H, 8'h00);
    send(spr_pkg::FRM_PIO_SETUP, 8'h00);
    rchk(spr_pkg::OFF_PORT_STATE, 32'h1);
    apb(1'b1, spr_pkg::OFF_SERIAL_CTL, {28'h0, spr_pkg::DET_COMRESET});
    repeat (3) @(posedge pclk);
    `CHK(comreset, 1'b1)
    apb(1'b0, spr_pkg::OFF_PORT_STATE, 32'h0);
    `CHK(rd[spr_pkg::PS_COMR_BIT], 1'b1)
    rchk(spr_pkg::OFF_TASK_FILE, 32'h7f);
    apb(1'b1, spr_pkg::OFF_SERIAL_CTL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(comreset, 1'b0)
    rchk(spr_pkg::OFF_PORT_STATE, 32'h0);
    results();
  end
endmodule // test_sata_port_pio_setup_recovery
